// ---- verilog/cam_counter_array.sv ----
// Counter array top: shared counter, AHB-Lite registers, five modules
// Function
// - Rising or falling capture bit set puts module in capture mode, pin sampled.
// - Valid pin edge copies counter high and low into compare bytes.
// - Interrupt request only when event flag and its enable are both set.
// - Compare enable plus hit enable makes a 16-bit software timer.
// - Writing compare high byte sets compare enable.
// - Writing compare low byte clears compare enable.
// - Compare enable stays directly writable in the mode register.
// - Flip, hit and compare enable set, PWM bit clear: pin inverts on each match.
// - PWM active when PWM bit and compare enable both set.
// - PWM pin low while counter low below compare low, else high.
// - In PWM mode, counter low wrap reloads compare low from compare high.
// - One shared counter: same PWM frequency, independent duty.
// - Only module 4 can be watchdog; otherwise usable in all modes.
// - Watchdog match raises internal reset, not the external reset pin.
// - Clearing guard enable blocks the watchdog reset.
// - Counter low byte at index e9, reset zero.
// - Rising capture bit selects positive edge, falling bit negative edge.
// - With hit enable, a match sets the module event flag.
//
// Chosen here: the AHB-Lite register port.
`default_nettype none
module cam_counter_array
    import cam_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Count source
    input wire logic count_pulse_i,
    // Module pins
    input wire logic [NUM_CHAN-1:0] module_pin_i,
    output logic [NUM_CHAN-1:0] module_pin_o,
    output logic [NUM_CHAN-1:0] module_pin_oe_o,
    // Requests
    output logic event_irq_o,
    output logic guard_reset_o
);
    cam_bus_state_t state;
    logic addr_ok;
    logic wr_pend;
    logic [7:0] idx_q;
    logic [7:0] rd_byte;
    logic wr_cl;
    logic wr_ch;
    logic wr_ctl;
    logic wr_guard;
    logic [15:0] count;
    logic tick_q;
    logic wrap;
    logic [NUM_CHAN-1:0] pin_s1;
    logic [NUM_CHAN-1:0] pin_s2;
    logic [NUM_CHAN-1:0] events;
    logic [NUM_CHAN-1:0] hits;
    logic [NUM_CHAN-1:0] irq_en;
    logic [NUM_CHAN-1:0] flags;
    logic guard_en;
    logic [7:0] mode_rd [NUM_CHAN];
    logic [7:0] low_rd [NUM_CHAN];
    logic [7:0] high_rd [NUM_CHAN];

    // Bus front end: writes take no wait, reads take one
    assign addr_ok = hsel_i & hready_i & htrans_i[1];
    assign hreadyout_o = (state != ST_RD_WAIT);
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_pend <= 1'b0;
            idx_q <= RST_BYTE;
        end
        else if (hready_i)
        begin
            wr_pend <= addr_ok & hwrite_i;
            if (addr_ok)
                idx_q <= haddr_i[ADDR_MSB:ADDR_LSB];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE:
                    if (addr_ok & ~hwrite_i)
                        state <= ST_RD_WAIT;
                ST_RD_WAIT:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            hrdata_o <= 32'h0000_0000;
        else if (state == ST_RD_WAIT)
            hrdata_o <= {24'h00_0000, rd_byte};
    end

    // Read mux; unmapped indices read zero
    always_comb
    begin
        rd_byte = RST_BYTE;
        if (idx_q == IDX_COUNTER_LOW)
            rd_byte = count[7:0];
        if (idx_q == IDX_COUNTER_HIGH)
            rd_byte = count[15:8];
        if (idx_q == IDX_ARRAY_CONTROL)
            rd_byte = {3'b000, flags};
        if (idx_q == IDX_GUARD_CONTROL)
            rd_byte = {7'b000_0000, guard_en};
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            if (idx_q == IDX_MODE0 + 8'(i))
                rd_byte = mode_rd[i];
            if (idx_q == IDX_COMPARE_LOW0 + 8'(i))
                rd_byte = low_rd[i];
            if (idx_q == IDX_COMPARE_HIGH0 + 8'(i))
                rd_byte = high_rd[i];
        end
    end

    assign wr_cl = wr_pend & (idx_q == IDX_COUNTER_LOW);
    assign wr_ch = wr_pend & (idx_q == IDX_COUNTER_HIGH);
    assign wr_ctl = wr_pend & (idx_q == IDX_ARRAY_CONTROL);
    assign wr_guard = wr_pend & (idx_q == IDX_GUARD_CONTROL);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count <= RST_COUNT;
        else if (wr_cl)
            count[7:0] <= hwdata_i[7:0];
        else if (wr_ch)
            count[15:8] <= hwdata_i[7:0];
        else if (count_pulse_i)
            count <= count + COUNT_STEP;
    end

    // Compares run only on a freshly advanced count
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            tick_q <= 1'b0;
        else
            tick_q <= count_pulse_i & ~wr_cl & ~wr_ch;
    end

    assign wrap = tick_q & (count[7:0] == LOW_WRAP);

    // Two-stage pin synchroniser
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end
        else
        begin
            pin_s1 <= module_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    for (genvar g = 0; g < NUM_CHAN; g++)
    begin : g_chan
        cam_chan_if link ();
        assign link.wr_mode = wr_pend & (idx_q == IDX_MODE0 + 8'(g));
        assign link.wr_low = wr_pend & (idx_q == IDX_COMPARE_LOW0 + 8'(g));
        assign link.wr_high = wr_pend & (idx_q == IDX_COMPARE_HIGH0 + 8'(g));
        assign link.wdata = hwdata_i[7:0];
        assign link.count = count;
        assign link.tick = tick_q;
        assign link.wrap = wrap;
        assign link.pin_s = pin_s2[g];
        assign mode_rd[g] = link.mode;
        assign low_rd[g] = link.cmp_low;
        assign high_rd[g] = link.cmp_high;
        assign events[g] = link.event_p;
        assign hits[g] = link.hit;
        assign irq_en[g] = link.mode[B_IRQ_EN];
        assign module_pin_o[g] = link.pin_o;
        assign module_pin_oe_o[g] = link.pin_oe;

        cam_channel u_chan (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .ch(link)
        );
    end

    // Event flags: a set in the clearing cycle survives
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flags <= '0;
        else if (wr_ctl)
            flags <= hwdata_i[NUM_CHAN-1:0] | events;
        else
            flags <= flags | events;
    end

    assign event_irq_o = |(flags & irq_en);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            guard_en <= 1'b0;
        else if (wr_guard)
            guard_en <= hwdata_i[B_GUARD_EN];
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            guard_reset_o <= 1'b0;
        else
            guard_reset_o <= guard_en & hits[WDT_CHAN];
    end
endmodule
`default_nettype wire

// ---- verilog/cam_pkg.sv ----
// Shared constants and types of the counter array
`default_nettype none
package cam_pkg;
    localparam int NUM_CHAN = 5;
    localparam int WDT_CHAN = 4;
    // Register indices; byte address is index times four
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 9;
    localparam logic [7:0] IDX_COUNTER_LOW = 8'he9;
    localparam logic [7:0] IDX_COUNTER_HIGH = 8'hf9;
    localparam logic [7:0] IDX_COMPARE_LOW0 = 8'hea;
    localparam logic [7:0] IDX_COMPARE_HIGH0 = 8'hfa;
    localparam logic [7:0] IDX_MODE0 = 8'hc0;
    localparam logic [7:0] IDX_ARRAY_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_GUARD_CONTROL = 8'hc9;
    // Module mode register fields
    localparam int B_IRQ_EN = 0;
    localparam int B_PWM = 1;
    localparam int B_FLIP = 2;
    localparam int B_HIT = 3;
    localparam int B_FALL = 4;
    localparam int B_RISE = 5;
    localparam int B_CMP_EN = 6;
    // Guard control field
    localparam int B_GUARD_EN = 0;
    // Reset values, count step and low-byte wrap value
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [7:0] LOW_WRAP = 8'h00;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RD_WAIT = 1'b1
    } cam_bus_state_t;
endpackage
`default_nettype wire

// ---- verilog/cam_chan_if.sv ----
// Link between the array core and one compare/capture module
`default_nettype none
interface cam_chan_if;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic [7:0] wdata;
    logic [15:0] count;
    logic tick;
    logic wrap;
    logic pin_s;
    logic [7:0] mode;
    logic [7:0] cmp_low;
    logic [7:0] cmp_high;
    logic event_p;
    logic hit;
    logic pin_o;
    logic pin_oe;
    modport ctrl (
        output wr_mode, wr_low, wr_high, wdata, count, tick, wrap, pin_s,
        input mode, cmp_low, cmp_high, event_p, hit, pin_o, pin_oe
    );
    modport chan (
        input wr_mode, wr_low, wr_high, wdata, count, tick, wrap, pin_s,
        output mode, cmp_low, cmp_high, event_p, hit, pin_o, pin_oe
    );
endinterface
`default_nettype wire

// ---- verilog/cam_channel.sv ----
// One compare/capture module: capture, timer, toggle output and PWM
`default_nettype none
module cam_channel
    import cam_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Link to the array core
    cam_chan_if.chan ch
);
    logic [7:0] mode;
    logic [7:0] cmp_low;
    logic [7:0] cmp_high;
    logic pin_prev;
    logic pin_q;
    logic rise;
    logic fall;
    logic capture;
    logic match;
    logic pwm_mode;
    logic flip_mode;

    assign rise = ch.pin_s & ~pin_prev & mode[B_RISE];
    assign fall = ~ch.pin_s & pin_prev & mode[B_FALL];
    assign capture = rise | fall;
    assign match = mode[B_CMP_EN] & ch.tick & (ch.count == {cmp_high, cmp_low});
    assign pwm_mode = mode[B_CMP_EN] & mode[B_PWM];
    assign flip_mode = mode[B_CMP_EN] & mode[B_HIT] & mode[B_FLIP];

    assign ch.mode = mode;
    assign ch.cmp_low = cmp_low;
    assign ch.cmp_high = cmp_high;
    assign ch.event_p = capture | (match & mode[B_HIT]);
    assign ch.hit = match & mode[B_HIT];
    assign ch.pin_o = pin_q;
    assign ch.pin_oe = pwm_mode | flip_mode;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pin_prev <= 1'b0;
        else
            pin_prev <= ch.pin_s;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            mode <= RST_BYTE;
        else if (ch.wr_mode)
            mode <= {1'b0, ch.wdata[6:0]};
        else if (ch.wr_high)
            mode[B_CMP_EN] <= 1'b1;
        else if (ch.wr_low)
            mode[B_CMP_EN] <= 1'b0;
    end

    // Capture beats reload, reload beats a software write
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cmp_low <= RST_BYTE;
        else if (capture)
            cmp_low <= ch.count[7:0];
        else if (pwm_mode & ch.wrap)
            cmp_low <= cmp_high;
        else if (ch.wr_low)
            cmp_low <= ch.wdata;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cmp_high <= RST_BYTE;
        else if (capture)
            cmp_high <= ch.count[15:8];
        else if (ch.wr_high)
            cmp_high <= ch.wdata;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pin_q <= 1'b0;
        else if (pwm_mode)
            pin_q <= (ch.count[7:0] >= cmp_low);
        else if (flip_mode & match)
            pin_q <= ~pin_q;
    end
endmodule
`default_nettype wire

// ---- bench/cam_props.sv ----
// Bus and request checks of the counter array at its ports
`default_nettype none
module cam_props
    import cam_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o,
    input wire logic count_pulse_i,
    input wire logic [NUM_CHAN-1:0] module_pin_oe_o,
    input wire logic guard_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic wtake;
    assign take = hsel_i && hready_i && htrans_i[1];
    assign wtake = take && hwrite_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_resp_okay:
        assert property (hresp_o == 1'b0) else $error("response not okay");
    chk_write_nowait:
        assert property (wtake |=> hreadyout_o) else $error("write stalled");
    chk_read_wait:
        assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
            else $error("read wait state wrong");
    chk_wait_origin:
        assert property (!hreadyout_o |-> $past(take && !hwrite_i))
            else $error("wait without read");
    chk_rdata_upper:
        assert property (hrdata_o[31:8] == 24'h000000) else $error("upper read bits set");
    chk_rdata_hold:
        assert property (hreadyout_o |=> $stable(hrdata_o)) else $error("read data moved");
    chk_guard_pulse:
        assert property (guard_reset_o |=> !guard_reset_o) else $error("reset pulse too long");
    chk_guard_cause:
        assert property (guard_reset_o |-> $past(count_pulse_i, 1) || $past(count_pulse_i, 2)
            || $past(count_pulse_i, 3)) else $error("reset without count");
    chk_oe_cause:
        assert property ($changed(module_pin_oe_o) |-> $past(wtake, 1) || $past(wtake, 2))
            else $error("enable changed without write");
endmodule
bind cam_counter_array cam_props i_cam_props (.clk_i, .reset_n_i, .hsel_i, .htrans_i,
    .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .count_pulse_i,
    .module_pin_oe_o, .guard_reset_o);
`default_nettype wire

// ---- bench/cam_pin_model.sv ----
// Pin partner: drives the module pins and yields where the array drives
`default_nettype none
module cam_pin_model
    import cam_pkg::*;
(
    input wire logic [NUM_CHAN-1:0] drive_i,
    input wire logic [NUM_CHAN-1:0] array_pin_i,
    input wire logic [NUM_CHAN-1:0] array_oe_i,
    output logic [NUM_CHAN-1:0] wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin driven by the array shows its level, the rest the model's level
    assign wire_o = (array_oe_i & array_pin_i) | (~array_oe_i & drive_i);
endmodule
`default_nettype wire

// ---- bench/cam_counter_array_tb.sv ----
// Register-level test of the counter array
`default_nettype none
module cam_counter_array_tb
    import cam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic cnt = 1'b0;
    logic [NUM_CHAN-1:0] drive = 5'h00;
    logic hrdy;
    logic hresp;
    logic [31:0] hrdata;
    logic [NUM_CHAN-1:0] pin_o;
    logic [NUM_CHAN-1:0] pin_oe;
    logic [NUM_CHAN-1:0] pin_w;
    logic irq;
    logic guard;
    logic [31:0] d;
    logic [7:0] n;
    int failures = 0;
    int cmp_count = 0;
    int guard_seen = 0;
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    cam_counter_array i_cam_counter_array (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hresp_o(hresp), .hrdata_o(hrdata), .count_pulse_i(cnt), .module_pin_i(pin_w),
        .module_pin_o(pin_o), .module_pin_oe_o(pin_oe), .event_irq_o(irq),
        .guard_reset_o(guard));
    cam_pin_model i_cam_pin_model (.drive_i(drive), .array_pin_i(pin_o),
        .array_oe_i(pin_oe), .wire_o(pin_w));
    always @(posedge clk_i)
    begin
        if (guard === 1'b1)
            guard_seen++;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask
    task automatic await_ready();
        int k;
        k = 0;
        @(posedge clk_i);
        while (hrdy !== 1'b1)
        begin
            k++;
            if (k > 20)
            begin
                failures++;
                conclude();
            end
            @(posedge clk_i);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h000000, idx, 2'h0};
        await_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        await_ready();
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, v);
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(d, {24'h000000, exp});
    endtask
    task automatic pulse(input int k);
        repeat (k)
        begin
            cnt <= 1'b1;
            @(posedge clk_i);
            cnt <= 1'b0;
            @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        rc(IDX_COUNTER_LOW, 8'h00);
        rc(IDX_GUARD_CONTROL, 8'h00);
        rc(8'h10, 8'h00);
        for (n = 8'h00; n < 8'h05; n++)
        begin
            rc(IDX_MODE0 + n, 8'h00);
            wr(IDX_COMPARE_HIGH0 + n, 8'h07);
            rc(IDX_MODE0 + n, 8'h40);
            wr(IDX_COMPARE_LOW0 + n, 8'h01);
            rc(IDX_MODE0 + n, 8'h00);
            wr(IDX_MODE0 + n, 8'h40);
            rc(IDX_MODE0 + n, 8'h40);
            rc(IDX_COMPARE_LOW0 + n, 8'h01);
            wr(IDX_MODE0 + n, 8'h00);
        end
        pulse(3);
        rc(IDX_COUNTER_LOW, 8'h03);
        wr(IDX_COUNTER_LOW, 8'h00);
        // Low byte first, non-zero compare before enabling
        wr(IDX_COMPARE_LOW0 + 8'h01, 8'h05);
        wr(IDX_COMPARE_HIGH0 + 8'h01, 8'h00);
        wr(IDX_MODE0 + 8'h01, 8'h49);
        wr(IDX_COMPARE_LOW0 + 8'h02, 8'h03);
        wr(IDX_COMPARE_HIGH0 + 8'h02, 8'h00);
        wr(IDX_MODE0 + 8'h02, 8'h4c);
        wr(IDX_COMPARE_LOW0 + 8'h04, 8'h04);
        wr(IDX_COMPARE_HIGH0 + 8'h04, 8'h00);
        wr(IDX_MODE0 + 8'h04, 8'h48);
        wr(IDX_GUARD_CONTROL, 8'h01);
        wr(IDX_ARRAY_CONTROL, 8'h00);
        pulse(3);
        chk1(pin_o[2], 1'b1);
        chk1(irq, 1'b0);
        pulse(1);
        check(guard_seen, 32'h1);
        pulse(1);
        rc(IDX_ARRAY_CONTROL, 8'h16);
        chk1(irq, 1'b1);
        wr(IDX_ARRAY_CONTROL, 8'h00);
        wr(IDX_GUARD_CONTROL, 8'h00);
        wr(IDX_COUNTER_LOW, 8'h00);
        pulse(4);
        check(guard_seen, 32'h1);
        chk1(pin_o[2], 1'b0);
        wr(IDX_MODE0 + 8'h03, 8'h20);
        wr(IDX_COUNTER_LOW, 8'h5a);
        drive[3] <= 1'b1;
        repeat (8) @(posedge clk_i);
        rc(IDX_COMPARE_LOW0 + 8'h03, 8'h5a);
        wr(IDX_MODE0 + 8'h03, 8'h10);
        wr(IDX_COUNTER_LOW, 8'h6b);
        drive[3] <= 1'b0;
        repeat (8) @(posedge clk_i);
        rc(IDX_COMPARE_LOW0 + 8'h03, 8'h6b);
        rc(IDX_COMPARE_HIGH0 + 8'h03, 8'h00);
        wr(IDX_COUNTER_HIGH, 8'h33);
        wr(IDX_COMPARE_LOW0, 8'h80);
        wr(IDX_COMPARE_HIGH0, 8'h40);
        wr(IDX_MODE0, 8'h42);
        @(posedge clk_i);
        chk1(pin_oe[0], 1'b1);
        wr(IDX_COUNTER_LOW, 8'h7e);
        pulse(1);
        chk1(pin_o[0], 1'b0);
        pulse(1);
        chk1(pin_o[0], 1'b1);
        wr(IDX_COUNTER_LOW, 8'hff);
        pulse(1);
        rc(IDX_COMPARE_LOW0, 8'h40);
        chk1(pin_o[0], 1'b0);
        rc(IDX_COUNTER_HIGH, 8'h34);
        // Keep the watchdog compare ahead of the counter
        wr(IDX_GUARD_CONTROL, 8'h01);
        wr(IDX_COMPARE_LOW0 + 8'h04, 8'h08);
        wr(IDX_COMPARE_HIGH0 + 8'h04, 8'h34);
        pulse(4);
        wr(IDX_COMPARE_LOW0 + 8'h04, 8'h10);
        wr(IDX_COMPARE_HIGH0 + 8'h04, 8'h34);
        pulse(4);
        check(guard_seen, 32'h1);
        pulse(8);
        check(guard_seen, 32'h2);
        conclude();
    end
    initial
    begin
        #800000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
